// File: rtl/reset_config_validation_seq.sv
`timescale 1ns/1ps
`default_nettype none
module reset_config_validation_seq
    import rst_seq_pkg::*;
#(
    parameter int NORMAL_CYC = NORMAL_RST_CYC,
    parameter int LONG_CYC   = LONG_RST_CYC
)(
    // clock and power-up reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // external reset pin, asynchronous
    input  wire logic                rst_pin_n,
    // address strap pins, shared with general outputs
    input  wire logic [3:0]          addr_strap_in,
    output logic      [3:0]          general_outputs,
    output logic      [3:0]          general_outputs_oe,
    input  wire logic [3:0]          general_outputs_value,
    // serial host front end
    input  wire logic                host_req,
    input  wire logic [3:0]          host_req_addr,
    output logic                     host_ack,
    // configuration access
    input  wire logic                cfg_wr_en,
    input  wire logic [CFG_AW-1:0]   cfg_wr_addr,
    input  wire logic [CFG_DW-1:0]   cfg_wr_data,
    input  wire logic [CFG_AW-1:0]   cfg_rd_addr,
    output logic      [CFG_DW-1:0]   cfg_rd_data,
    // status
    output logic                     in_reset,
    output logic      [3:0]          dev_addr,
    output logic                     cfg_bad,
    output logic                     cfg_new
);
    typedef struct packed {
        seq_e               st;
        logic [1:0]         pin_sync;
        logic [3:0]         strap_s1;
        logic [3:0]         strap_s2;
        logic [5:0]         idx;
        logic               rd_vld;
        logic [5:0]         rd_idx;
        logic [CFG_DW-1:0]  sum;
        logic [CFG_DW-1:0]  last_user;
        logic               differ;
        logic               restore;
        logic [TIMER_W-1:0] timer;
        logic [TIMER_W-1:0] target;
        logic               wr_en;
        logic [CFG_AW:0]    wr_addr;
        logic [CFG_DW-1:0]  wr_data;
        logic               in_reset;
        logic [3:0]         dev_addr;
        logic [3:0]         gen_out;
        logic [3:0]         gen_oe;
        logic               host_ack;
        logic               cfg_bad;
        logic               cfg_new;
    } seq_s;

    localparam logic [TIMER_W-1:0] NORMAL_T = TIMER_W'(NORMAL_CYC);
    localparam logic [TIMER_W-1:0] LONG_T   = TIMER_W'(LONG_CYC);

    seq_s              r;
    seq_s              next_r;
    logic [CFG_AW:0]   mem_rd_addr;
    logic              mem_wr_en;
    logic [CFG_AW:0]   mem_wr_addr;
    logic [CFG_DW-1:0] mem_wr_data;
    logic [CFG_DW-1:0] mem_rd_data;

    cfg_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // host writes go straight in only while running; the sequencer owns the port otherwise
    always_comb begin
        if (r.st == ST_RUN) begin
            mem_wr_en   = cfg_wr_en;
            mem_wr_addr = {BANK_USER, cfg_wr_addr};
            mem_wr_data = cfg_wr_data;
        end else begin
            mem_wr_en   = r.wr_en;
            mem_wr_addr = r.wr_addr;
            mem_wr_data = r.wr_data;
        end
        unique case (r.st)
            ST_SCAN:  mem_rd_addr = {r.idx[0], r.idx[4:1]};
            ST_COPY:  mem_rd_addr = {r.restore, r.idx[3:0]};
            ST_RUN:   mem_rd_addr = {r.restore, cfg_rd_addr};
            default:  mem_rd_addr = '0;
        endcase
    end

    always_comb begin
        next_r          = r;
        next_r.pin_sync = {r.pin_sync[0], rst_pin_n};
        next_r.strap_s1 = addr_strap_in;
        next_r.strap_s2 = r.strap_s1;
        next_r.rd_vld   = 1'b0;
        next_r.wr_en    = 1'b0;
        next_r.host_ack = 1'b0;
        if (r.st != ST_RUN) begin
            next_r.timer = r.timer + 1'b1;
        end
        unique case (r.st)
            ST_START: begin
                // leaves on the first cycle, well inside the start bound
                next_r.idx      = '0;
                next_r.sum      = '0;
                next_r.differ   = 1'b0;
                next_r.timer    = '0;
                next_r.in_reset = 1'b1;
                next_r.gen_oe   = '0;
                next_r.gen_out  = '0;
                next_r.st       = ST_SCAN;
            end
            ST_SCAN: begin
                // user and backup words interleave; the sum covers the user bank
                if (!r.idx[5]) begin
                    next_r.idx    = r.idx + 1'b1;
                    next_r.rd_vld = 1'b1;
                    next_r.rd_idx = r.idx;
                end
                if (r.rd_vld) begin
                    if (!r.rd_idx[0]) begin
                        next_r.sum       = r.sum + mem_rd_data;
                        next_r.last_user = mem_rd_data;
                    end else if (mem_rd_data != r.last_user) begin
                        next_r.differ = 1'b1;
                    end
                    if (r.rd_idx == 6'h1F) begin
                        next_r.st = ST_DECIDE;
                    end
                end
            end
            ST_DECIDE: begin
                next_r.cfg_bad  = (r.sum != '0);
                next_r.cfg_new  = (r.sum == '0) && r.differ;
                next_r.restore  = (r.sum != '0);
                next_r.dev_addr = r.strap_s2;
                next_r.idx      = '0;
                if (r.sum != '0 || r.differ) begin
                    next_r.target = LONG_T;
                    next_r.st     = ST_COPY;
                end else begin
                    next_r.target = NORMAL_T;
                    next_r.st     = ST_HOLD;
                end
            end
            ST_COPY: begin
                // restore copies backup to user, otherwise user is saved as backup
                if (!r.idx[4]) begin
                    next_r.idx    = r.idx + 1'b1;
                    next_r.rd_vld = 1'b1;
                    next_r.rd_idx = r.idx;
                end
                if (r.rd_vld) begin
                    next_r.wr_en   = 1'b1;
                    next_r.wr_addr = {~r.restore, r.rd_idx[3:0]};
                    next_r.wr_data = mem_rd_data;
                    if (r.rd_idx[3:0] == CFG_LAST) begin
                        next_r.st = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // length is counted from the start, so both reset causes match
                if (r.timer >= r.target - 1'b1) begin
                    next_r.in_reset = 1'b0;
                    next_r.gen_oe   = '1;
                    next_r.st       = ST_RUN;
                end
            end
            ST_RUN: begin
                next_r.gen_out  = general_outputs_value;
                next_r.host_ack = host_req && (host_req_addr == r.dev_addr);
            end
        endcase
        // a low pin, however short after sync, restarts the same sequence
        if (!r.pin_sync[1]) begin
            next_r.st       = ST_START;
            next_r.in_reset = 1'b1;
            next_r.gen_oe   = '0;
            next_r.gen_out  = '0;
            next_r.host_ack = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r           <= '0;
            r.st        <= ST_START;
            r.pin_sync  <= 2'h3;
            r.in_reset  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign general_outputs    = r.gen_out;
    assign general_outputs_oe = r.gen_oe;
    assign host_ack           = r.host_ack;
    assign cfg_rd_data        = mem_rd_data;
    assign in_reset           = r.in_reset;
    assign dev_addr           = r.dev_addr;
    assign cfg_bad            = r.cfg_bad;
    assign cfg_new            = r.cfg_new;
endmodule : reset_config_validation_seq
`default_nettype wire

// File: rtl/rst_seq_pkg.sv
package rst_seq_pkg;
    // clock and sequence timing
    localparam int CLK_KHZ        = 200_000;
    localparam int NORMAL_RST_MS  = 35;
    localparam int LONG_RST_MS    = 120;
    localparam int START_MAX_MS   = 2;
    localparam int PIN_LOW_MIN_NS = 2000;
    localparam int NORMAL_RST_CYC = NORMAL_RST_MS * CLK_KHZ;
    localparam int LONG_RST_CYC   = LONG_RST_MS * CLK_KHZ;
    localparam int START_MAX_CYC  = START_MAX_MS * CLK_KHZ;
    localparam int PIN_LOW_MIN_CYC = (PIN_LOW_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int TIMER_W        = 25;

    // configuration memory: two banks of words, last word of a bank balances the sum to zero
    localparam int CFG_AW         = 4;
    localparam int CFG_DW         = 8;
    localparam int CFG_WORDS      = 16;
    localparam logic [CFG_AW-1:0] CFG_LAST = 4'hF;
    localparam logic BANK_USER    = 1'b0;
    localparam logic BANK_BACKUP  = 1'b1;
    localparam logic [CFG_DW-1:0] CFG_RESET_WORD = 8'h00;

    typedef enum {ST_START, ST_SCAN, ST_DECIDE, ST_COPY, ST_HOLD, ST_RUN} seq_e;
endpackage : rst_seq_pkg

// File: rtl/cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_mem
    import rst_seq_pkg::*;
(
    // clock
    input  wire logic                clk,
    // write port
    input  wire logic                wr_en,
    input  wire logic [CFG_AW:0]     wr_addr,
    input  wire logic [CFG_DW-1:0]   wr_data,
    // read port, data one cycle later
    input  wire logic [CFG_AW:0]     rd_addr,
    output var  logic [CFG_DW-1:0]   rd_data
);
    logic [CFG_DW-1:0] mem [2*CFG_WORDS];

    // contents survive sys_rst like a stored configuration would
    initial begin
        for (int i = 0; i < 2 * CFG_WORDS; i++) begin
            mem[i] = CFG_RESET_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : cfg_mem
`default_nettype wire

// File: bench/rst_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rst_seq_chk #(
    parameter int NORMAL_CYC = 200,
    parameter int LONG_CYC   = 400
)(
    // clock and resets
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       rst_pin_n,
    // shared pins
    input wire logic [3:0] general_outputs,
    input wire logic [3:0] general_outputs_oe,
    input wire logic [3:0] general_outputs_value,
    // host side
    input wire logic       host_req,
    input wire logic       host_ack,
    input wire logic [3:0] host_req_addr,
    input wire logic [3:0] dev_addr,
    // status
    input wire logic       in_reset,
    input wire logic       cfg_bad,
    input wire logic       cfg_new
);
    // pin sync latency makes the measured length a few cycles loose
    int len;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) len <= 0;
        else if (!rst_pin_n) len <= 0;
        else if (in_reset) len <= len + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_short_when_same: assert property ($fell(in_reset) && !cfg_bad && !cfg_new |->
        len >= NORMAL_CYC - 2 && len <= NORMAL_CYC + 5) else $error("short reset length off");
    a_long_when_changed: assert property ($fell(in_reset) && (cfg_bad || cfg_new) |->
        len >= LONG_CYC - 2 && len <= LONG_CYC + 5) else $error("long reset length off");
    a_len_bounded: assert property (len <= LONG_CYC + 5) else $error("reset too long");
    a_no_ack_reset: assert property (host_ack |->
        $past(!in_reset && host_req && host_req_addr == dev_addr)) else $error("stray ack");
    a_ack_in_run: assert property (host_req && !in_reset && host_req_addr == dev_addr |=>
        host_ack) else $error("missing ack");
    a_pins_released: assert property (in_reset |-> general_outputs_oe == 4'h0 &&
        general_outputs == 4'h0) else $error("pins driven in reset");
    a_pins_driven: assert property (!in_reset |-> general_outputs_oe == 4'hF) else $error("pins idle");
    a_addr_held: assert property (!in_reset |-> $stable(dev_addr)) else $error("address moved");
    a_pin_forces: assert property (!rst_pin_n [*5] |-> in_reset) else $error("pin ignored");
    a_outputs_follow: assert property (!in_reset ##1 !in_reset |->
        general_outputs == $past(general_outputs_value)) else $error("outputs wrong");
    c_ack: cover property (host_ack);
    c_bad: cover property ($fell(in_reset) && cfg_bad);
    c_new: cover property ($fell(in_reset) && cfg_new);
    c_normal: cover property ($fell(in_reset) && !cfg_bad && !cfg_new);
endmodule : rst_seq_chk
bind reset_config_validation_seq rst_seq_chk #(.NORMAL_CYC(NORMAL_CYC), .LONG_CYC(LONG_CYC)) chk_i (.*);
`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // bench control
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       go,
    input  wire logic       early,
    input  wire logic [3:0] addr,
    // device side
    input  wire logic       in_reset,
    input  wire logic       host_ack,
    output var  logic       host_req,
    output var  logic [3:0] host_req_addr,
    output var  logic [7:0] acks
);
    // idle address toggles so a stale value never looks like a match two cycles running
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_req <= 1'b0;
            host_req_addr <= 4'h0;
            acks <= 8'h00;
        end else begin
            host_req <= go && (early || !in_reset);
            host_req_addr <= go ? addr : ~host_req_addr;
            acks <= acks + 8'(host_ack);
        end
    end
endmodule : host_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rst_seq_pkg::*;
    localparam int NC = 200;
    localparam int LC = 400;
    logic clk = 0, sys_rst = 1, rst_pin_n = 1, go = 0, early = 1, cfg_wr_en = 0;
    logic [3:0] addr_strap_in = 4'h5, general_outputs_value = 4'h0, haddr = 4'h0;
    logic [3:0] cfg_wr_addr = 4'h0, cfg_rd_addr = 4'h0, general_outputs, general_outputs_oe;
    logic [3:0] host_req_addr, dev_addr;
    logic [7:0] cfg_wr_data = 8'h00, cfg_rd_data, acks;
    logic [7:0] img [16];
    logic host_req, host_ack, in_reset, cfg_bad, cfg_new;
    int errors = 0, checks_done = 0, seed = 7104;
    always #2.5 clk = ~clk;
    reset_config_validation_seq #(.NORMAL_CYC(NC), .LONG_CYC(LC)) dut (
        .clk                   (clk),
        .sys_rst               (sys_rst),
        .rst_pin_n             (rst_pin_n),
        .addr_strap_in         (addr_strap_in),
        .general_outputs       (general_outputs),
        .general_outputs_oe    (general_outputs_oe),
        .general_outputs_value (general_outputs_value),
        .host_req              (host_req),
        .host_req_addr         (host_req_addr),
        .host_ack              (host_ack),
        .cfg_wr_en             (cfg_wr_en),
        .cfg_wr_addr           (cfg_wr_addr),
        .cfg_wr_data           (cfg_wr_data),
        .cfg_rd_addr           (cfg_rd_addr),
        .cfg_rd_data           (cfg_rd_data),
        .in_reset              (in_reset),
        .dev_addr              (dev_addr),
        .cfg_bad               (cfg_bad),
        .cfg_new               (cfg_new)
    );
    host_model host (.clk, .sys_rst, .go, .early, .addr(haddr), .in_reset, .host_ack,
        .host_req, .host_req_addr, .acks);
    function automatic int exp_ack(input logic [3:0] a, d);
        return (a === d) ? 1 : 0;
    endfunction : exp_ack
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_len(input int got, exp);
        chk(32'(got >= exp - 2 && got <= exp + 5), 32'h1);
    endtask : chk_len
    task automatic wait_run(input int exp);
        int n;
        logic [7:0] a0;
        n = 0;
        a0 = acks;
        while (in_reset !== 1'b0 && n < LC + 50) begin
            @(posedge clk);
            haddr <= dev_addr;
            early <= 1'b1;
            go <= (n == 20);
            n++;
        end
        go <= 0;
        if (n >= LC + 50) begin
            errors++;
            summarize();
        end
        chk_len(n, exp);
        chk(8'(acks - a0), 32'h0);
        chk(dev_addr, addr_strap_in);
    endtask : wait_run
    task automatic pin_reset(input int exp);
        @(posedge clk);
        addr_strap_in <= 4'($random(seed));
        rst_pin_n <= 0;
        repeat (PIN_LOW_MIN_CYC) @(posedge clk);
        chk(in_reset, 32'h1);
        chk(general_outputs, 32'h0);
        rst_pin_n <= 1;
        wait_run(exp);
    endtask : pin_reset
    task automatic traffic;
        logic [7:0] a0;
        logic [3:0] a;
        int n;
        a0 = acks;
        n = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            a = ($random(seed) & 1) ? dev_addr : 4'($random(seed));
            haddr <= a;
            early <= 1'b0;
            go <= 1;
            general_outputs_value <= 4'($random(seed));
            n += exp_ack(a, dev_addr);
        end
        @(posedge clk);
        go <= 0;
        repeat (3) @(posedge clk);
        chk(8'(acks - a0), n);
        chk(general_outputs, general_outputs_value);
    endtask : traffic
    task automatic load_cfg(input logic bad);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (!bad) img[i] = (i == 15) ? 8'(8'h00 - s) : 8'($random(seed));
            s = s + img[i];
            @(posedge clk);
            cfg_wr_en <= 1;
            cfg_wr_addr <= 4'(i);
            cfg_wr_data <= img[i] ^ ((bad && i == 3) ? 8'h01 : 8'h00);
        end
        @(posedge clk);
        cfg_wr_en <= 0;
    endtask : load_cfg
    task automatic read_cfg;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            cfg_rd_addr <= 4'(i);
            @(posedge clk);
            @(negedge clk);
            chk(cfg_rd_data, img[i]);
        end
    endtask : read_cfg
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        wait_run(NC);
        traffic();
        load_cfg(0);
        pin_reset(LC);
        chk(cfg_new, 1);
        read_cfg();
        pin_reset(NC);
        chk(cfg_new, 0);
        load_cfg(1);
        pin_reset(LC);
        chk(cfg_bad, 1);
        read_cfg();
        traffic();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wait_run(NC);
        chk(cfg_bad, 32'h0);
        chk(cfg_new, 32'h0);
        read_cfg();
        summarize();
    end
endmodule : testbench
`default_nettype wire
